/* File: ldc_pkg.sv */
package ldc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets in configuration space
  localparam logic [7:0] ERR_CLKREQ_CTRL_OFS = 8'hc0;
  localparam logic [7:0] LINK_PWR_TIMER_OFS = 8'hc4;

  // reset values and writable masks
  localparam logic [31:0] ERR_CLKREQ_CTRL_RST = 32'h00000001;
  localparam logic [31:0] ERR_CLKREQ_CTRL_WMASK = 32'h0004cf87;
  localparam logic [31:0] LINK_PWR_TIMER_RST = 32'h00120108;
  localparam logic [31:0] LINK_PWR_TIMER_WMASK = 32'h001fffff;

  // first register field positions
  localparam int CAPT_BUSDEV_LSB = 19;
  localparam int ADVISORY_ERR_BIT = 18;
  localparam int MEM_CFG_ACCESS_BIT = 2;
  localparam int CLKREQ_FORCE_BIT = 0;

  // second register field positions
  localparam int L1_LAT_SEP_LSB = 18;
  localparam int L1_LAT_SHARED_LSB = 15;
  localparam int SEC_RESET_BLOCK_BIT = 10;
  localparam int L1_ENTRY_LSB = 6;
  localparam int STANDBY_ENTRY_LSB = 2;

  // timing: clock period and timer tick lengths
  localparam int CLK_PERIOD_PS = 10000;
  localparam int L1_TICK_PS = 512000;
  localparam int STANDBY_TICK_PS = 16000;
  localparam int L1_TICK_CYC = (L1_TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STANDBY_TICK_CYC = (STANDBY_TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

/* File: ldc_timer_if.sv */
`timescale 1ns/1ps
`default_nettype none

// idle request, programmed limit and expiry of one entry timer
interface ldc_timer_if;
  logic idle;
  logic [3:0] limit;
  logic expire;
  modport ctrl (output idle, output limit, input expire);
  modport timer (input idle, input limit, output expire);
endinterface

`default_nettype wire

/* File: ldc_entry_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module ldc_entry_timer #(
  parameter int TICK_CYC = 2
) (
  // clock and control
  input wire logic clk,
  input wire logic rstN,
  input wire logic ce,
  // timer carrier
  ldc_timer_if.timer tif
);

  logic [6:0] preReg, preNext;
  logic [3:0] cntReg, cntNext;
  logic expReg, expNext;

  ////////////////////////////////////////////////////////////////////////////
  // counts whole ticks while idle, expires once the tick count meets the limit
  always_comb begin
    preNext = preReg;
    cntNext = cntReg;
    expNext = 1'b0;
    if (!tif.idle) begin
      preNext = '0;
      cntNext = '0;
    end else begin
      expNext = (cntReg == tif.limit);
      if (preReg == 7'(TICK_CYC - 1)) begin
        preNext = '0;
        cntNext = (cntReg == tif.limit) ? cntReg : cntReg + 4'h1;
      end else begin
        preNext = preReg + 7'h01;
      end
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (!rstN) begin
      preReg <= '0;
      cntReg <= '0;
      expReg <= 1'b0;
    end else if (ce) begin
      preReg <= preNext;
      cntReg <= cntNext;
      expReg <= expNext;
    end
  end

  assign tif.expire = expReg;

  // expiry only follows a period of idle
  a_expire_needs_idle: assert property (@(posedge clk) disable iff (!rstN)
    (ce && $past(ce) && tif.expire) |-> $past(tif.idle)) else $error("timer expired without idle");

endmodule

`default_nettype wire

/* File: ldc_regs.sv */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - bit 18 clear reports advisory non-fatal errors; set means not supported.
// - read-only reserved bits of both registers always read zero.
// - bit 2 set accepts config accesses to memory-mapped registers; clear refuses.
// - bit 0 set holds the clock request output asserted; resets to one.
// - shared clock set mirrors separate-clock L1 exit latency into link capability.
// - shared clock clear mirrors shared-clock L1 exit latency into link capability.
// - bit 10 set blocks the secondary bus reset from bridge control.
// - L1 entry timer counts the bits 9:6 value in 512 ns ticks.
// - standby entry timer counts the bits 5:2 value in 62.5 MHz ticks.
// - fundamental, global or power-on reset restores every writable field.
module ldc_regs (
  // clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // reset pins
  input wire logic fundResetN,
  input wire logic globalResetInputN,
  // configuration access
  input wire logic cfgRead,
  input wire logic cfgWrite,
  input wire logic [7:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWrData,
  output logic cfgHit,
  output logic cfgRdValid,
  output logic [31:0] cfgRdData,
  // eeprom load
  input wire logic eeWrite,
  input wire logic [7:0] eeAddr,
  input wire logic [31:0] eeData,
  // captured bus and device number
  input wire logic [12:0] capturedBusDev,
  // link and bridge side
  input wire logic sharedClockConfigBit,
  input wire logic secondaryBusResetBit,
  input wire logic clkReqInternal,
  input wire logic memCfgReq,
  input wire logic l1Idle,
  input wire logic standbyIdle,
  output logic memCfgAccept,
  output logic advisoryErrorSelect,
  output logic clockRequestOut,
  output logic [2:0] linkCapA,
  output logic secondaryResetOut,
  output logic l1EntryExpire,
  output logic standbyEntryExpire
);

  // merges a write into a register through byte enables and writable mask
  function automatic logic [31:0] applyWrite(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] laneMask;
    laneMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
    return (old & ~laneMask) | (data & laneMask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset pin synchronisers
  logic [1:0] rstMetaReg, rstSyncReg;
  logic rstAllN;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rstMetaReg <= 2'h0;
      rstSyncReg <= 2'h0;
    end else if (ce) begin
      rstMetaReg <= {globalResetInputN, fundResetN};
      rstSyncReg <= rstMetaReg;
    end
  end

  // any of the three resets restores the fields
  assign rstAllN = nrst & rstSyncReg[0] & rstSyncReg[1];

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [31:0] errCtrlReg, errCtrlNext;
  logic [31:0] pwrTimerReg, pwrTimerNext;

  // eeprom load wins over a configuration write in the same cycle
  always_comb begin
    errCtrlNext = errCtrlReg;
    pwrTimerNext = pwrTimerReg;
    if (eeWrite) begin
      if (eeAddr == ldc_pkg::ERR_CLKREQ_CTRL_OFS)
        errCtrlNext = applyWrite(errCtrlReg, eeData, 4'hf, ldc_pkg::ERR_CLKREQ_CTRL_WMASK);
      if (eeAddr == ldc_pkg::LINK_PWR_TIMER_OFS)
        pwrTimerNext = applyWrite(pwrTimerReg, eeData, 4'hf, ldc_pkg::LINK_PWR_TIMER_WMASK);
    end else if (cfgWrite) begin
      if (cfgAddr == ldc_pkg::ERR_CLKREQ_CTRL_OFS)
        errCtrlNext = applyWrite(errCtrlReg, cfgWrData, cfgByteEn, ldc_pkg::ERR_CLKREQ_CTRL_WMASK);
      if (cfgAddr == ldc_pkg::LINK_PWR_TIMER_OFS)
        pwrTimerNext = applyWrite(pwrTimerReg, cfgWrData, cfgByteEn, ldc_pkg::LINK_PWR_TIMER_WMASK);
    end
  end

  // register storage
  always_ff @(posedge clk) begin
    if (!rstAllN) begin
      errCtrlReg <= ldc_pkg::ERR_CLKREQ_CTRL_RST;
      pwrTimerReg <= ldc_pkg::LINK_PWR_TIMER_RST;
    end else if (ce) begin
      errCtrlReg <= errCtrlNext;
      pwrTimerReg <= pwrTimerNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  logic [31:0] rdDataNext;
  logic rdValidNext;

  assign cfgHit = (cfgAddr == ldc_pkg::ERR_CLKREQ_CTRL_OFS) || (cfgAddr == ldc_pkg::LINK_PWR_TIMER_OFS);

  // reserved read-only bits come back as zero, unmapped reads as zero
  always_comb begin
    rdValidNext = cfgRead;
    rdDataNext = '0;
    if (cfgRead && cfgAddr == ldc_pkg::ERR_CLKREQ_CTRL_OFS) begin
      rdDataNext = errCtrlReg & ldc_pkg::ERR_CLKREQ_CTRL_WMASK;
      rdDataNext[31:ldc_pkg::CAPT_BUSDEV_LSB] = capturedBusDev;
    end else if (cfgRead && cfgAddr == ldc_pkg::LINK_PWR_TIMER_OFS) begin
      rdDataNext = pwrTimerReg & ldc_pkg::LINK_PWR_TIMER_WMASK;
    end
  end

  // read data registers
  always_ff @(posedge clk) begin
    if (!rstAllN) begin
      cfgRdValid <= 1'b0;
      cfgRdData <= '0;
    end else if (ce) begin
      cfgRdValid <= rdValidNext;
      cfgRdData <= rdDataNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control outputs driven from the fields
  logic advisoryNext, clkReqNext, secResetNext;
  logic [2:0] linkCapNext;

  always_comb begin
    advisoryNext = errCtrlReg[ldc_pkg::ADVISORY_ERR_BIT];
    clkReqNext = errCtrlReg[ldc_pkg::CLKREQ_FORCE_BIT] | clkReqInternal;
    secResetNext = secondaryBusResetBit & ~pwrTimerReg[ldc_pkg::SEC_RESET_BLOCK_BIT];
    if (sharedClockConfigBit)
      linkCapNext = pwrTimerReg[ldc_pkg::L1_LAT_SEP_LSB +: 3];
    else
      linkCapNext = pwrTimerReg[ldc_pkg::L1_LAT_SHARED_LSB +: 3];
  end

  // output registers
  always_ff @(posedge clk) begin
    if (!rstAllN) begin
      advisoryErrorSelect <= 1'b0;
      clockRequestOut <= 1'b1;
      secondaryResetOut <= 1'b0;
      linkCapA <= 3'h4;
    end else if (ce) begin
      advisoryErrorSelect <= advisoryNext;
      clockRequestOut <= clkReqNext;
      secondaryResetOut <= secResetNext;
      linkCapA <= linkCapNext;
    end
  end

  // memory-mapped configuration access gate
  assign memCfgAccept = memCfgReq & errCtrlReg[ldc_pkg::MEM_CFG_ACCESS_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // entry timers
  ldc_timer_if l1If ();
  ldc_timer_if standbyIf ();

  assign l1If.idle = l1Idle;
  assign l1If.limit = pwrTimerReg[ldc_pkg::L1_ENTRY_LSB +: 4];
  assign standbyIf.idle = standbyIdle;
  assign standbyIf.limit = pwrTimerReg[ldc_pkg::STANDBY_ENTRY_LSB +: 4];
  assign l1EntryExpire = l1If.expire;
  assign standbyEntryExpire = standbyIf.expire;

  ldc_entry_timer #(.TICK_CYC(ldc_pkg::L1_TICK_CYC)) l1Timer (
    .clk(clk),
    .rstN(rstAllN),
    .ce(ce),
    .tif(l1If.timer)
  );

  ldc_entry_timer #(.TICK_CYC(ldc_pkg::STANDBY_TICK_CYC)) standbyTimer (
    .clk(clk),
    .rstN(rstAllN),
    .ce(ce),
    .tif(standbyIf.timer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_full_write_c4;
    ce && cfgWrite && !eeWrite && cfgAddr == 8'hc4 && cfgByteEn == 4'hf;
  endsequence

  sequence s_read_c4;
    ce && cfgRead && cfgAddr == 8'hc4;
  endsequence

  a_advisory_follows: assert property (@(posedge clk) disable iff (!rstAllN)
    ce |=> advisoryErrorSelect == $past(errCtrlReg[18])) else $error("advisory select mismatch");

  a_reserved_read_zero: assert property (@(posedge clk) disable iff (!rstAllN)
    cfgRdValid |-> ((cfgRdData & 32'h00033078) == 32'h0 || $past(cfgAddr) != 8'hc0) &&
                   (cfgRdData[31:21] == 11'h0 || $past(cfgAddr) != 8'hc4)) else $error("reserved bits read nonzero");

  a_mem_access_gate: assert property (@(posedge clk) disable iff (!rstAllN)
    memCfgReq |-> memCfgAccept == errCtrlReg[2]) else $error("memory config access gate wrong");

  a_clkreq_forced: assert property (@(posedge clk) disable iff (!rstAllN)
    (ce && errCtrlReg[0]) |=> clockRequestOut) else $error("clock request not forced");

  a_link_cap_sep: assert property (@(posedge clk) disable iff (!rstAllN)
    (ce && sharedClockConfigBit) |=> linkCapA == $past(pwrTimerReg[20:18])) else $error("separate latency not mirrored");

  a_link_cap_shared: assert property (@(posedge clk) disable iff (!rstAllN)
    (ce && !sharedClockConfigBit) |=> linkCapA == $past(pwrTimerReg[17:15])) else $error("shared latency not mirrored");

  a_sec_reset_block: assert property (@(posedge clk) disable iff (!rstAllN)
    (ce && pwrTimerReg[10]) |=> !secondaryResetOut) else $error("secondary reset not blocked");

  a_l1_expire_time: assert property (@(posedge clk) disable iff (!rstAllN)
    (ce && l1Idle && pwrTimerReg[9:6] == 4'h0 && !$past(l1Idle)) ##1 (ce && l1Idle) |-> l1EntryExpire)
    else $error("l1 entry timer late");

  a_standby_expire: assert property (@(posedge clk) disable iff (!rstAllN)
    (ce && standbyIdle && pwrTimerReg[5:2] == 4'h1 && !$past(standbyIdle)) ##1 (ce && standbyIdle) [*2] ##1 ce
    |-> standbyEntryExpire) else $error("standby entry timer wrong");

  a_reset_values: assert property (@(posedge clk)
    !rstAllN |=> errCtrlReg == 32'h00000001 && pwrTimerReg == 32'h00120108) else $error("reset values wrong");

  a_write_readback: assert property (@(posedge clk) disable iff (!rstAllN)
    s_full_write_c4 ##1 (ce && !cfgWrite && !eeWrite) ##1 s_read_c4
    |=> cfgRdData == ($past(cfgWrData, 3) & 32'h001fffff)) else $error("write readback wrong");

endmodule

`default_nettype wire

/* File: ldc_cfg_host.sv */
`timescale 1ns/1ps
`default_nettype none

// root complex side: issues config reads, config writes and eeprom loads
module ldc_cfg_host (
  // clock
  input wire logic clk,
  // configuration access
  output logic cfgRead,
  output logic cfgWrite,
  output logic [7:0] cfgAddr,
  output logic [3:0] cfgByteEn,
  output logic [31:0] cfgWrData,
  input wire logic cfgRdValid,
  input wire logic [31:0] cfgRdData,
  // eeprom load
  output logic eeWrite,
  output logic [7:0] eeAddr,
  output logic [31:0] eeData
);
  ////////////////////////////////////////////////////////////////////////////
  // quiet bus at time zero
  initial begin
    {cfgRead, cfgWrite, eeWrite} = 3'h0;
    {cfgAddr, eeAddr, cfgByteEn} = 20'h0;
    {cfgWrData, eeData} = 64'h0;
  end

  // reserved writable bits leave this side as zero while a write or load strobe is high
  function automatic logic [31:0] clean(input logic [7:0] a, input logic [31:0] d);
    return (a == ldc_pkg::ERR_CLKREQ_CTRL_OFS) ? (d & ~32'h0000cf82) : (d & ~32'h00007803);
  endfunction

  // one write strobe; released address and data show inverted values, not stale ones; byte enables keep their value
  task automatic cfgWr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    cfgWrite <= 1'h1;
    cfgAddr <= a;
    cfgByteEn <= be;
    cfgWrData <= clean(a, d);
    @(posedge clk);
    cfgWrite <= 1'h0;
    cfgAddr <= ~a;
    cfgWrData <= ~clean(a, d);
  endtask

  // eeprom word load, always a full word
  task automatic eeWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    eeWrite <= 1'h1;
    eeAddr <= a;
    eeData <= clean(a, d);
    @(posedge clk);
    eeWrite <= 1'h0;
    eeAddr <= ~a;
    eeData <= ~clean(a, d);
  endtask

  // read strobe; data and valid taken in the cycle after it is sampled
  task automatic cfgRd(input logic [7:0] a, output logic [31:0] d, output logic ok);
    @(posedge clk);
    cfgRead <= 1'h1;
    cfgAddr <= a;
    @(posedge clk);
    cfgRead <= 1'h0;
    cfgAddr <= ~a;
    #1;
    ok = cfgRdValid;
    d = cfgRdData;
  endtask
endmodule

`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk, nrst, ce, fundResetN, globalResetInputN;
  logic cfgRead, cfgWrite, cfgHit, cfgRdValid, eeWrite;
  logic [7:0] cfgAddr, eeAddr;
  logic [3:0] cfgByteEn;
  logic [31:0] cfgWrData, cfgRdData, eeData, bd;
  logic [12:0] capturedBusDev;
  logic sharedClockConfigBit, secondaryBusResetBit, clkReqInternal, memCfgReq, l1Idle, standbyIdle;
  logic memCfgAccept, advisoryErrorSelect, clockRequestOut, secondaryResetOut, l1EntryExpire, standbyEntryExpire;
  logic [2:0] linkCapA;
  int errorCnt = 0;
  int compares = 0;
  localparam logic [7:0] C0 = ldc_pkg::ERR_CLKREQ_CTRL_OFS;
  localparam logic [7:0] C4 = ldc_pkg::LINK_PWR_TIMER_OFS;
  localparam logic [31:0] LV = 32'h000e844c; // sep 3, shared 5, block, l1 1, standby 3
  assign bd = {capturedBusDev, 19'h0};

  ldc_regs ldc_regs_inst (.clk(clk), .nrst(nrst), .ce(ce), .fundResetN(fundResetN),
    .globalResetInputN(globalResetInputN), .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
    .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgHit(cfgHit), .cfgRdValid(cfgRdValid),
    .cfgRdData(cfgRdData), .eeWrite(eeWrite), .eeAddr(eeAddr), .eeData(eeData),
    .capturedBusDev(capturedBusDev), .sharedClockConfigBit(sharedClockConfigBit),
    .secondaryBusResetBit(secondaryBusResetBit), .clkReqInternal(clkReqInternal), .memCfgReq(memCfgReq),
    .l1Idle(l1Idle), .standbyIdle(standbyIdle), .memCfgAccept(memCfgAccept),
    .advisoryErrorSelect(advisoryErrorSelect), .clockRequestOut(clockRequestOut), .linkCapA(linkCapA),
    .secondaryResetOut(secondaryResetOut), .l1EntryExpire(l1EntryExpire),
    .standbyEntryExpire(standbyEntryExpire));
  ldc_cfg_host ldc_cfg_host_inst (.clk(clk), .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
    .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdValid(cfgRdValid), .cfgRdData(cfgRdData),
    .eeWrite(eeWrite), .eeAddr(eeAddr), .eeData(eeData));

  ////////////////////////////////////////////////////////////////////////////
  // clock generator
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // verdict and end of run
  task automatic stopTest();
    if (errorCnt == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errorCnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic ok;
    logic hit;
    fork
      ldc_cfg_host_inst.cfgRd(a, d, ok);
      begin
        @(posedge clk);
        #1;
        hit = cfgHit;
      end
    join
    chk({31'h0, hit}, {31'h0, (a == C0 || a == C4)});
    chk({31'h0, ok}, 32'h1);
    chk(d, e);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // defaults after power-on reset
  task automatic testResetValues();
    rdChk(C0, ldc_pkg::ERR_CLKREQ_CTRL_RST | bd);
    rdChk(C4, ldc_pkg::LINK_PWR_TIMER_RST);
    rdChk(8'h80, 32'h0);
    chk({31'h0, clockRequestOut}, 32'h1);
    chk({29'h0, linkCapA}, 32'h4);
    chk({31'h0, advisoryErrorSelect}, 32'h0);
    chk({31'h0, memCfgAccept}, 32'h0);
  endtask

  // first register: reserved bits, advisory select, access enable, clock request
  task automatic testErrCtrl();
    ldc_cfg_host_inst.cfgWr(C0, 32'hffffffff, 4'hf);
    rdChk(C0, 32'h00040005 | bd);
    chk({31'h0, advisoryErrorSelect}, 32'h1);
    chk({31'h0, memCfgAccept}, 32'h1);
    @(posedge clk);
    memCfgReq <= 1'h0;
    tick(1);
    chk({31'h0, memCfgAccept}, 32'h0);
    @(posedge clk);
    memCfgReq <= 1'h1;
    ldc_cfg_host_inst.cfgWr(C0, 32'h0, 4'hb);
    rdChk(C0, 32'h00040000 | bd);
    chk({31'h0, clockRequestOut}, 32'h0);
    chk({31'h0, memCfgAccept}, 32'h0);
    @(posedge clk);
    clkReqInternal <= 1'h1;
    tick(2);
    chk({31'h0, clockRequestOut}, 32'h1);
    @(posedge clk);
    clkReqInternal <= 1'h0;
  endtask

  // second register: mirror select and secondary reset block
  task automatic testLinkPwr();
    ldc_cfg_host_inst.cfgWr(C4, 32'hffffffff, 4'hf);
    rdChk(C4, 32'h001f87fc);
    ldc_cfg_host_inst.eeWr(C4, LV);
    rdChk(C4, LV);
    chk({31'h0, secondaryResetOut}, 32'h0);
    @(posedge clk);
    sharedClockConfigBit <= 1'h1;
    tick(2);
    chk({29'h0, linkCapA}, 32'h3);
    @(posedge clk);
    sharedClockConfigBit <= 1'h0;
    tick(2);
    chk({29'h0, linkCapA}, 32'h5);
    ldc_cfg_host_inst.eeWr(C4, LV & ~32'h400);
    rdChk(C4, LV & ~32'h400);
    chk({31'h0, secondaryResetOut}, 32'h1);
  endtask

  // idle-to-expiry delay of one entry timer
  task automatic timeEntry(input logic l1, input int expCyc);
    int n;
    @(posedge clk);
    if (l1) l1Idle <= 1'h1;
    else standbyIdle <= 1'h1;
    n = 0;
    do begin
      tick(1);
      n++;
    end while ((l1 ? l1EntryExpire : standbyEntryExpire) !== 1'h1 && n < 300);
    chk(32'(n), 32'(expCyc));
    if (n >= 300) stopTest();
    @(posedge clk);
    l1Idle <= 1'h0;
    standbyIdle <= 1'h0;
    tick(3);
    chk({30'h0, l1EntryExpire, standbyEntryExpire}, 32'h0);
  endtask

  // each reset pin restores both registers
  task automatic testPinReset();
    for (int s = 0; s < 2; s++) begin
      ldc_cfg_host_inst.cfgWr(C4, LV, 4'hf);
      @(posedge clk);
      if (s == 0) fundResetN <= 1'h0;
      else globalResetInputN <= 1'h0;
      tick(4);
      @(posedge clk);
      {fundResetN, globalResetInputN} <= 2'h3;
      tick(4);
      rdChk(C4, ldc_pkg::LINK_PWR_TIMER_RST);
      rdChk(C0, ldc_pkg::ERR_CLKREQ_CTRL_RST | bd);
    end
  endtask

  // a write while the clock enable is low leaves the register untouched
  task automatic testFreeze();
    @(posedge clk);
    ce <= 1'h0;
    ldc_cfg_host_inst.cfgWr(C4, 32'h0, 4'hf);
    @(posedge clk);
    ce <= 1'h1;
    rdChk(C4, ldc_pkg::LINK_PWR_TIMER_RST);
  endtask

  // main sequence
  initial begin
    {nrst, l1Idle, standbyIdle, sharedClockConfigBit, clkReqInternal} = 5'h0;
    {ce, fundResetN, globalResetInputN, memCfgReq, secondaryBusResetBit} = 5'h1f;
    capturedBusDev = 13'h0a5a;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    tick(4);
    testResetValues();
    testErrCtrl();
    testLinkPwr();
    timeEntry(1'h0, 3 * ldc_pkg::STANDBY_TICK_CYC + 1);
    timeEntry(1'h1, ldc_pkg::L1_TICK_CYC + 1);
    ldc_cfg_host_inst.cfgWr(C4, 32'h000e8404, 4'hf); // l1 limit 0, standby limit 1
    timeEntry(1'h0, ldc_pkg::STANDBY_TICK_CYC + 1);
    timeEntry(1'h1, 1);
    testPinReset();
    testFreeze();
    stopTest();
  end
endmodule

`default_nettype wire
